// [adcfr_frontend.sv]
// Front end configuration and rate control of a delta-sigma converter.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`default_nettype none

module adcfr_frontend
	import adcfr_pkg::*;
#(
	parameter logic [12:0] MOD_PER_WORD = 13'(ADCFR_MOD_PER_WORD)
)
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output var  logic [31:0] dat_o,
	output var  logic        ack_o,
	input  wire logic        osc_clk_i,
	input  wire logic        input_buffer_enable_pin_i,
	input  wire logic        sensor_open_i,
	input  wire logic [23:0] conversion_data_i,
	output var  logic [3:0]  pos_channel_o,
	output var  logic [3:0]  neg_channel_o,
	output var  logic        burnout_source_enable_o,
	output var  logic        input_buffer_active_o,
	output var  logic [2:0]  input_gain_amplifier_o,
	output var  logic [7:0]  offset_correction_value_o,
	output var  logic        modulator_tick_o,
	output var  logic        result_ready_n_o
);

	// Two flip-flops per pin: osc clock, buffer pin, sensor open flag.
	typedef struct packed {
		logic [2:0]  sync1;
		logic [2:0]  sync2;
		logic        osc_prev;
		logic        osc_tick;
		logic        ack;
		logic [31:0] dat;
		logic [3:0]  pos;
		logic [3:0]  neg;
		logic [2:0]  gain;
		logic        burn;
		logic        speed;
		logic        buf_bit;
		logic [1:0]  rate;
		logic [7:0]  offset_correction_value;
		logic [23:0] result;
		logic        rdy_n;
		logic        buf_act;
		logic        mod_tick;
	} adcfr_fe_s;

	adcfr_fe_s state_ff;
	adcfr_fe_s nxt_state;

	logic       mod_tick;
	logic       word_warn;
	logic       word_start;
	logic       act_speed;
	logic [1:0] act_rate;

	adcfr_rate_gen #(
		.MOD_PER_WORD (MOD_PER_WORD)
	) u_rate_gen (
		.clock_i      (clock_i),
		.rst_i        (rst_i),
		.osc_tick_i   (state_ff.osc_tick),
		.speed_i      (state_ff.speed),
		.rate_i       (state_ff.rate),
		.mod_tick_o   (mod_tick),
		.word_warn_o  (word_warn),
		.word_start_o (word_start),
		.speed_o      (act_speed),
		.rate_o       (act_rate)
	);

	function automatic logic chan_ok(input logic [3:0] ch);
		// Channels 0 to 7 and the common input are legal.
		chan_ok = (ch <= ADCFR_CH_COMMON);
	endfunction

	always_comb
	begin
		logic       req;
		logic       wr;
		logic       rd_result;
		logic [3:0] wpos;
		logic [3:0] wneg;
		logic [1:0] wrate;
		logic       pin_buf;
		logic       pin_open;
		req       = cyc_i && stb_i && !state_ff.ack;
		wr        = req && we_i && sel_i[0];
		rd_result = req && !we_i && (adr_i == ADCFR_OFS_RESULT);
		wpos      = dat_i[ADCFR_MUX_POS_LSB +: 4];
		wneg      = dat_i[ADCFR_MUX_NEG_LSB +: 4];
		wrate     = dat_i[ADCFR_ACR_RATE_LSB +: 2];
		pin_buf   = state_ff.sync2[1];
		pin_open  = state_ff.sync2[2];
		nxt_state = state_ff;

		nxt_state.sync1 = {sensor_open_i, input_buffer_enable_pin_i,
			osc_clk_i};
		nxt_state.sync2 = state_ff.sync1;
		nxt_state.osc_prev = state_ff.sync2[0];
		nxt_state.osc_tick = state_ff.sync2[0] && !state_ff.osc_prev;
		nxt_state.mod_tick = mod_tick;

		// Every access is answered one cycle after the request.
		nxt_state.ack = req;
		nxt_state.dat = 32'h0000_0000;
		if (wr)
		begin
			unique case (adr_i)
				ADCFR_OFS_MUX:
				begin
					// Each side is steered alone; a bad code keeps its old value.
					if (chan_ok(wpos))
					begin
						nxt_state.pos = wpos;
					end
					if (chan_ok(wneg))
					begin
						nxt_state.neg = wneg;
					end
				end
				ADCFR_OFS_SETUP:
				begin
					nxt_state.gain = dat_i[ADCFR_SETUP_GAIN_LSB +: 3];
					nxt_state.burn = dat_i[ADCFR_SETUP_BURN_BIT];
					nxt_state.speed = dat_i[ADCFR_SETUP_SPEED_BIT];
				end
				ADCFR_OFS_ACR:
				begin
					nxt_state.buf_bit = dat_i[ADCFR_ACR_BUF_BIT];
					if (wrate != ADCFR_RATE_RESERVED)
					begin
						nxt_state.rate = wrate;
					end
				end
				ADCFR_OFS_OFFSET_CORRECTION_VALUE:
				begin
					nxt_state.offset_correction_value = dat_i[7:0];
				end
				default:
				begin
					nxt_state.ack = req;
				end
			endcase
		end
		else if (req)
		begin
			unique case (adr_i)
				ADCFR_OFS_MUX:
				begin
					nxt_state.dat[ADCFR_MUX_POS_LSB +: 4] = state_ff.pos;
					nxt_state.dat[ADCFR_MUX_NEG_LSB +: 4] = state_ff.neg;
				end
				ADCFR_OFS_SETUP:
				begin
					nxt_state.dat[ADCFR_SETUP_GAIN_LSB +: 3] = state_ff.gain;
					nxt_state.dat[ADCFR_SETUP_BURN_BIT] = state_ff.burn;
					nxt_state.dat[ADCFR_SETUP_SPEED_BIT] = state_ff.speed;
				end
				ADCFR_OFS_ACR:
				begin
					nxt_state.dat[ADCFR_ACR_RATE_LSB +: 2] = state_ff.rate;
					nxt_state.dat[ADCFR_ACR_BUF_BIT] = state_ff.buf_bit;
				end
				ADCFR_OFS_OFFSET_CORRECTION_VALUE:
				begin
					nxt_state.dat[7:0] = state_ff.offset_correction_value;
				end
				ADCFR_OFS_RESULT:
				begin
					nxt_state.dat[23:0] = state_ff.result;
				end
				ADCFR_OFS_STATUS:
				begin
					nxt_state.dat[ADCFR_ST_READY_BIT] = !state_ff.rdy_n;
					nxt_state.dat[ADCFR_ST_BUFACT_BIT] = state_ff.buf_act;
					nxt_state.dat[ADCFR_ST_BUFPIN_BIT] = pin_buf;
					nxt_state.dat[ADCFR_ST_RATE_LSB +: 2] = act_rate;
					nxt_state.dat[ADCFR_ST_SPEED_BIT] = act_speed;
				end
				default:
				begin
					nxt_state.dat = 32'h0000_0000;
				end
			endcase
		end

		// Buffer runs only with both the pin and the bit high.
		nxt_state.buf_act = pin_buf && state_ff.buf_bit;

		// Reading the result, or the coming word, releases the ready line.
		if (rd_result || word_warn)
		begin
			nxt_state.rdy_n = 1'b1;
		end
		// A word start wins over a read in the same cycle.
		if (word_start)
		begin
			nxt_state.rdy_n = 1'b0;
			// Each word start loads a new result, overwriting the previous one even if it was never read.
			if (state_ff.burn && pin_open)
			begin
				nxt_state.result = ADCFR_FULL_SCALE;
			end
			else
			begin
				nxt_state.result = conversion_data_i;
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_ff <= '0;
			state_ff.pos <= ADCFR_RST_POS;
			state_ff.neg <= ADCFR_RST_NEG;
			state_ff.gain <= ADCFR_RST_GAIN;
			state_ff.rate <= ADCFR_RST_RATE;
			state_ff.offset_correction_value <= ADCFR_RST_OFFSET_CORRECTION_VALUE;
			state_ff.result <= ADCFR_RST_RESULT;
			state_ff.rdy_n <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign dat_o                     = state_ff.dat;
	assign ack_o                     = state_ff.ack;
	assign pos_channel_o             = state_ff.pos;
	assign neg_channel_o             = state_ff.neg;
	assign burnout_source_enable_o   = state_ff.burn;
	assign input_buffer_active_o     = state_ff.buf_act;
	assign input_gain_amplifier_o    = state_ff.gain;
	assign offset_correction_value_o = state_ff.offset_correction_value;
	assign modulator_tick_o          = state_ff.mod_tick;
	assign result_ready_n_o          = state_ff.rdy_n;

endmodule // adcfr_frontend

`default_nettype wire

// [adcfr_pkg.sv]
// Constants shared by the converter front end and rate control block.
`default_nettype none

package adcfr_pkg;

	// Register byte offsets on the bus.
	localparam logic [7:0] ADCFR_OFS_MUX    = 8'h00;
	localparam logic [7:0] ADCFR_OFS_SETUP  = 8'h04;
	localparam logic [7:0] ADCFR_OFS_ACR    = 8'h08;
	localparam logic [7:0] ADCFR_OFS_OFFSET_CORRECTION_VALUE   = 8'h0c;
	localparam logic [7:0] ADCFR_OFS_RESULT = 8'h10;
	localparam logic [7:0] ADCFR_OFS_STATUS = 8'h14;

	// Input multiplexer channel register fields.
	localparam int ADCFR_MUX_POS_LSB = 4;
	localparam int ADCFR_MUX_NEG_LSB = 0;
	localparam logic [3:0] ADCFR_CH_COMMON = 4'h8;

	// Setup register fields.
	localparam int ADCFR_SETUP_GAIN_LSB = 0;
	localparam int ADCFR_SETUP_BURN_BIT = 3;
	localparam int ADCFR_SETUP_SPEED_BIT = 4;

	// Analog control register fields.
	localparam int ADCFR_ACR_RATE_LSB = 0;
	localparam int ADCFR_ACR_BUF_BIT  = 2;
	localparam logic [1:0] ADCFR_RATE_RESERVED = 2'h3;

	// Status register fields.
	localparam int ADCFR_ST_READY_BIT  = 0;
	localparam int ADCFR_ST_BUFACT_BIT = 1;
	localparam int ADCFR_ST_BUFPIN_BIT = 2;
	localparam int ADCFR_ST_RATE_LSB   = 3;
	localparam int ADCFR_ST_SPEED_BIT  = 5;

	// Values after reset.
	localparam logic [3:0] ADCFR_RST_POS   = 4'h0;
	localparam logic [3:0] ADCFR_RST_NEG   = 4'h1;
	localparam logic [2:0] ADCFR_RST_GAIN  = 3'h0;
	localparam logic [1:0] ADCFR_RST_RATE  = 2'h0;
	localparam logic [7:0] ADCFR_RST_OFFSET_CORRECTION_VALUE  = 8'h00;
	localparam logic [23:0] ADCFR_RST_RESULT = 24'h00_0000;

	// Positive full-scale code given for an open sensor.
	localparam logic [23:0] ADCFR_FULL_SCALE = 24'h07_ffff;

	// Modulator clock derivation from the oscillator.
	localparam int ADCFR_OSC_RATE_HZ = 2457600;
	localparam int ADCFR_MOD_RATE_HZ = 19200;
	localparam int ADCFR_MOD_DIV = ADCFR_OSC_RATE_HZ / ADCFR_MOD_RATE_HZ;
	localparam logic [7:0] ADCFR_OSC_LAST_FAST = 8'(ADCFR_MOD_DIV - 1);
	localparam logic [7:0] ADCFR_OSC_LAST_SLOW = 8'(2 * ADCFR_MOD_DIV - 1);

	// Modulator clocks per output word at the fastest rate.
	localparam int ADCFR_MOD_PER_WORD = 1280;

endpackage : adcfr_pkg

`default_nettype wire

// [adcfr_rate_gen.sv]
// Modulator clock divider and output word timing for the converter.
`default_nettype none

module adcfr_rate_gen
	import adcfr_pkg::*;
#(
	parameter logic [12:0] MOD_PER_WORD = 13'(ADCFR_MOD_PER_WORD)
)
(
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       osc_tick_i,
	input  wire logic       speed_i,
	input  wire logic [1:0] rate_i,
	output var  logic       mod_tick_o,
	output var  logic       word_warn_o,
	output var  logic       word_start_o,
	output var  logic       speed_o,
	output var  logic [1:0] rate_o
);

	typedef struct packed {
		logic [7:0]  osc_cnt;
		logic [12:0] mod_cnt;
		logic        speed;
		logic [1:0]  rate;
		logic        mod_tick;
		logic        warn;
		logic        start;
	} adcfr_rg_s;

	adcfr_rg_s state_ff;
	adcfr_rg_s nxt_state;

	always_comb
	begin
		logic [7:0]  osc_last;
		logic [12:0] word_last;
		osc_last  = state_ff.speed ? ADCFR_OSC_LAST_SLOW : ADCFR_OSC_LAST_FAST;
		word_last = 13'((MOD_PER_WORD << state_ff.rate) - 13'd1);
		nxt_state = state_ff;
		nxt_state.mod_tick = 1'b0;
		nxt_state.warn = 1'b0;
		nxt_state.start = 1'b0;
		if (osc_tick_i)
		begin
			// The speed bit picks the oscillator divide ratio.
			if (state_ff.osc_cnt >= osc_last)
			begin
				nxt_state.osc_cnt = 8'h00;
				nxt_state.mod_tick = 1'b1;
			end
			else
			begin
				nxt_state.osc_cnt = state_ff.osc_cnt + 8'h01;
			end
		end
		if (state_ff.mod_tick)
		begin
			if (state_ff.mod_cnt >= word_last)
			begin
				nxt_state.mod_cnt = 13'h0000;
				nxt_state.start = 1'b1;
				// New settings are taken only at a word boundary.
				nxt_state.speed = speed_i;
				nxt_state.rate = rate_i;
			end
			else
			begin
				nxt_state.mod_cnt = state_ff.mod_cnt + 13'h0001;
				nxt_state.warn = (state_ff.mod_cnt == 13'(word_last - 13'd1));
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_ff <= '0;
			state_ff.rate <= ADCFR_RST_RATE;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign mod_tick_o   = state_ff.mod_tick;
	assign word_warn_o  = state_ff.warn;
	assign word_start_o = state_ff.start;
	assign speed_o      = state_ff.speed;
	assign rate_o       = state_ff.rate;

endmodule // adcfr_rate_gen

`default_nettype wire

// [adcfr_checker_properties.sv]
// Concurrent checks on the ports of the converter front end.
`default_nettype none

module adcfr_checker
	import adcfr_pkg::*;
(
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic        ack_o,
	input wire logic        input_buffer_enable_pin_i,
	input wire logic [3:0]  pos_channel_o,
	input wire logic [3:0]  neg_channel_o,
	input wire logic        burnout_source_enable_o,
	input wire logic        input_buffer_active_o,
	input wire logic [2:0]  input_gain_amplifier_o,
	input wire logic [7:0]  offset_correction_value_o,
	input wire logic        modulator_tick_o,
	input wire logic        result_ready_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       wr;
	logic [9:0] gap_ff;
	logic       seen_ff;
	assign wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
	// Clocks since the last tick; two clocks per oscillator edge at best.
	always_ff @(posedge clock_i)
	begin
		if (rst_i | modulator_tick_o)
			gap_ff <= 10'h000;
		else if (gap_ff != 10'h3ff)
			gap_ff <= gap_ff + 10'h001;
		seen_ff <= ~rst_i & (seen_ff | modulator_tick_o);
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	AST_MUX_POS: assert property (
		wr && adr_i == ADCFR_OFS_MUX && dat_i[7:4] <= 4'h8
		|=> pos_channel_o == $past(dat_i[7:4])) else $error("pos channel");
	AST_MUX_RANGE: assert property (
		pos_channel_o <= 4'h8 && neg_channel_o <= 4'h8) else $error("chan");
	AST_GAIN: assert property (
		wr && adr_i == ADCFR_OFS_SETUP
		|=> input_gain_amplifier_o == $past(dat_i[2:0])) else $error("gain");
	AST_BURN: assert property (
		wr && adr_i == ADCFR_OFS_SETUP
		|=> burnout_source_enable_o == $past(dat_i[3])) else $error("burn");
	AST_OFFSET_CORRECTION_VALUE: assert property (
		wr && adr_i == ADCFR_OFS_OFFSET_CORRECTION_VALUE
		|=> offset_correction_value_o == $past(dat_i[7:0])) else $error("ofs");
	AST_BUF_PIN: assert property (
		(!input_buffer_enable_pin_i) [*4] |-> !input_buffer_active_o)
		else $error("buffer on with pin low");
	AST_READY_FALL: assert property (
		$fell(result_ready_n_o) |-> $past(modulator_tick_o) ||
		$past(modulator_tick_o, 2) || $past(modulator_tick_o, 3))
		else $error("ready fell away from a tick");
	AST_TICK_GAP: assert property (
		modulator_tick_o && seen_ff |-> gap_ff >= 10'h0fe)
		else $error("modulator ticks too close");
	cover property ($fell(result_ready_n_o));
	cover property (burnout_source_enable_o && !result_ready_n_o);
	cover property (input_buffer_active_o);
endmodule // adcfr_checker

`default_nettype wire

// [adcfr_osc_model.sv]
// Free running oscillator source feeding the converter clock pin.
`default_nettype none

module adcfr_osc_model
(
	input  wire logic clock_i,
	output wire logic osc_clk_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_ff = 2'h0;
	always_ff @(posedge clock_i)
		cnt_ff <= cnt_ff + 2'h1;
	assign osc_clk_o = cnt_ff[1];
endmodule // adcfr_osc_model

`default_nettype wire

// [tb.sv]
// Self-checking bench of the converter front end and rate control.
`default_nettype none

module tb
	import adcfr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [12:0] MPW = 13'h0004;
	typedef struct packed {logic [7:0] a; logic [31:0] d, e;} adcfr_row_s;
	adcfr_row_s  rows[7] = '{'{ADCFR_OFS_MUX, 32'h84, 32'h84},
		'{ADCFR_OFS_MUX, 32'h93, 32'h83}, '{ADCFR_OFS_MUX, 32'h08, 32'h08},
		'{ADCFR_OFS_MUX, 32'h57, 32'h57}, '{ADCFR_OFS_OFFSET_CORRECTION_VALUE, 32'h85, 32'h85},
		'{ADCFR_OFS_OFFSET_CORRECTION_VALUE, 32'h7f, 32'h7f}, '{8'h20, 32'hff, 32'h00}};
	logic        clock_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        osc;
	logic        pin;
	logic        sopen;
	logic [23:0] cdat;
	logic [3:0]  pos;
	logic [3:0]  neg;
	logic        burn;
	logic        bact;
	logic [2:0]  gain;
	logic [7:0]  ofs;
	logic        tick;
	logic        rdy_n;
	logic [31:0] q;
	logic [1:0]  rt;
	int          n_fail;
	int          n_tests;
	int          t;
	int          c;
	adcfr_frontend #(.MOD_PER_WORD(MPW)) i_adcfr_frontend (.clock_i(clock_i),
		.rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .osc_clk_i(osc),
		.input_buffer_enable_pin_i(pin), .sensor_open_i(sopen),
		.conversion_data_i(cdat), .pos_channel_o(pos), .neg_channel_o(neg),
		.burnout_source_enable_o(burn), .input_buffer_active_o(bact),
		.input_gain_amplifier_o(gain), .offset_correction_value_o(ofs),
		.modulator_tick_o(tick), .result_ready_n_o(rdy_n));
	adcfr_osc_model i_adcfr_osc_model (.clock_i(clock_i), .osc_clk_o(osc));
	task automatic end_of_test();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
			n_fail++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock_i);
		{cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hf};
		k = 0;
		do
		begin
			@(posedge clock_i);
			k++;
		end
		while (ack !== 1'b1 && k < 50);
		q = rdat;
		{cyc, stb} <= 2'h0;
		if (k >= 50)
		begin
			n_fail++;
			end_of_test();
		end
	endtask
	// Waits for the next fall of ready; counts ticks and the last tick gap.
	task automatic word();
		int k;
		int s;
		logic p;
		{t, k, s} = 0;
		do
		begin
			p = rdy_n;
			@(posedge clock_i);
			k++;
			s++;
			if (tick === 1'b1)
			begin
				t++;
				c = s;
				s = 0;
			end
		end
		while (!(p === 1'b1 && rdy_n === 1'b0) && k < 30000);
		if (k >= 30000)
		begin
			n_fail++;
			end_of_test();
		end
	endtask
	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	initial
	begin
		{rst_i, cyc, stb, we, adr, sel, wdat, pin, sopen} = 50'h2_0000_0000_0000;
		{n_fail, n_tests, rt} = 0;
		cdat = 24'h12_3456;
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		chk({23'h0, pos, neg, rdy_n}, 32'h0000_0003);
		bus(1'b0, ADCFR_OFS_MUX, 32'h0);
		chk(q, 32'h0000_0001);
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			chk(q, rows[i].e);
			if (rows[i].a == ADCFR_OFS_MUX)
				chk({24'h0, pos, neg}, rows[i].e);
		end
		for (int g = 0; g < 8; g++)
		begin
			bus(1'b1, ADCFR_OFS_SETUP, 32'(g));
			chk({29'h0, gain}, 32'(g));
		end
		bus(1'b1, ADCFR_OFS_ACR, 32'h4);
		repeat (5) @(posedge clock_i);
		chk({31'h0, bact}, 32'h0);
		pin <= 1'b1;
		repeat (5) @(posedge clock_i);
		chk({31'h0, bact}, 32'h1);
		bus(1'b1, ADCFR_OFS_ACR, 32'h0);
		repeat (2) @(posedge clock_i);
		chk({31'h0, bact}, 32'h0);
		sopen <= 1'b1;
		bus(1'b1, ADCFR_OFS_SETUP, 32'h8);
		chk({31'h0, burn}, 32'h1);
		word();
		bus(1'b0, ADCFR_OFS_RESULT, 32'h0);
		chk(q, {8'h0, ADCFR_FULL_SCALE});
		repeat (2) @(posedge clock_i);
		chk({31'h0, rdy_n}, 32'h1);
		bus(1'b1, ADCFR_OFS_SETUP, 32'h0);
		sopen <= 1'b0;
		word();
		bus(1'b1, ADCFR_OFS_MUX, 32'h28);
		word();
		bus(1'b0, ADCFR_OFS_RESULT, 32'h0);
		chk(q, {8'h0, cdat});
		foreach (rows[i])
		begin
			if (i < 3)
			begin
				bus(1'b1, ADCFR_OFS_ACR, 32'((i + 1) % 3));
				bus(1'b0, ADCFR_OFS_STATUS, 32'h0);
				chk({30'h0, q[4:3]}, {30'h0, rt});
				rt = 2'((i + 1) % 3);
				word();
				word();
				chk(32'(t), 32'(MPW) << rt);
			end
		end
		chk(32'(c), 32'd512);
		bus(1'b1, ADCFR_OFS_SETUP, 32'h10);
		word();
		word();
		chk(32'(c), 32'd1024);
		end_of_test();
	end
endmodule // tb

bind adcfr_frontend adcfr_checker i_adcfr_checker (.clock_i(clock_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
	.input_buffer_enable_pin_i(input_buffer_enable_pin_i),
	.pos_channel_o(pos_channel_o), .neg_channel_o(neg_channel_o),
	.burnout_source_enable_o(burnout_source_enable_o),
	.input_buffer_active_o(input_buffer_active_o),
	.input_gain_amplifier_o(input_gain_amplifier_o),
	.offset_correction_value_o(offset_correction_value_o),
	.modulator_tick_o(modulator_tick_o), .result_ready_n_o(result_ready_n_o));

`default_nettype wire
